// >>> src/rtc_interrupt_routing.sv
// Interrupt routing, output pin control and day alarm for the RTC section.
`timescale 1ns/10ps
`default_nettype none
module rtc_interrupt_routing (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        watchdog_timeout,
   input  wire logic        powerfail_detect,
   input  wire logic        day_tick,
   input  wire logic [5:0]  current_day_bcd,
   output logic             int_o,
   output logic             int_oe,
   output logic             irq
);
   import rtc_irq_pkg::*;

   logic [7:0]        ctrl_q;
   logic [7:0]        day_q;
   logic [NFLAGS-1:0] flags_q;
   logic [NFLAGS-1:0] mask_q;
   logic [NFLAGS-1:0] event_d;
   logic [NFLAGS-1:0] route_d;
   logic              alarm_match;
   logic              flag_read;
   logic              active_q;
   logic [7:0]        pulse_q;
   logic [31:0]       awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_held_q;
   logic              w_held_q;
   logic              wr_go;
   logic [31:0]       rdata_d;
   logic              rd_ok;

   // Each register owns one aligned word, so the index starts above the two
   // byte-lane bits. Upper address bits are not decoded and the map repeats,
   // which keeps the compare narrow at the cost of aliases.
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = IDX_LSB + 16;

   // Alarm match: a new day equal to the stored date, unless the date is masked.
   always_comb begin
      alarm_match = day_tick && (day_q[DAY_MASK_BIT] ||
                    ((day_q & DAY_VAL_MASK) == {2'h0, current_day_bcd}));
      event_d = '0;
      event_d[FLG_WD] = watchdog_timeout;
      event_d[FLG_AL] = alarm_match;
      event_d[FLG_PF] = powerfail_detect;
      route_d = '0;
      route_d[FLG_WD] = watchdog_timeout && ctrl_q[BIT_WIE];
      route_d[FLG_AL] = alarm_match && ctrl_q[BIT_AIE];
      route_d[FLG_PF] = powerfail_detect && ctrl_q[BIT_POWERFAIL_IRQ_ENABLE];
   end

   // AXI write: address and data may arrive in either order.
   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_q[IDX_MSB:IDX_LSB])
               ADDR_ALARM_DAY, ADDR_IRQ_CTRL, ADDR_FLAGS, ADDR_MASK:
                  s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Both halves taken at one edge must be answered two edges later.
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |=> ##1 s_axi_bvalid)
      else $error("write was not answered in time");

   // Control and day alarm registers; reserved bits never store a one.
   // Writes use byte lane 0 only, since every register here is a single byte.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= RESET_BYTE;
         day_q  <= RESET_BYTE;
         mask_q <= '0;
      end else if (wr_go && wstrb_q[0]) begin
         case (awaddr_q[IDX_MSB:IDX_LSB])
            ADDR_IRQ_CTRL:  ctrl_q <= wdata_q[7:0] & CTRL_WR_MASK;
            ADDR_ALARM_DAY: day_q  <= wdata_q[7:0] & DAY_WR_MASK;
            ADDR_MASK:      mask_q <= wdata_q[NFLAGS-1:0];
            default: ;
         endcase
      end
   end

   a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wstrb_q[0] && awaddr_q[IDX_MSB:IDX_LSB] == ADDR_IRQ_CTRL
      |=> ctrl_q == (wdata_q[7:0] & CTRL_WR_MASK))
      else $error("control write stored the wrong value");
   a_day_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wstrb_q[0] && awaddr_q[IDX_MSB:IDX_LSB] == ADDR_ALARM_DAY
      |=> day_q == (wdata_q[7:0] & DAY_WR_MASK))
      else $error("day alarm write stored the wrong value");
   a_mask_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wstrb_q[0] && awaddr_q[IDX_MSB:IDX_LSB] == ADDR_MASK
      |=> mask_q == wdata_q[NFLAGS-1:0])
      else $error("mask write stored the wrong value");

   // Sticky flags: every event sets its flag whatever the enables; set beats clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= '0;
      end else begin
         if (wr_go && wstrb_q[0] && awaddr_q[IDX_MSB:IDX_LSB] == ADDR_FLAGS)
            flags_q <= (flags_q & ~wdata_q[NFLAGS-1:0]) | event_d;
         else
            flags_q <= flags_q | event_d;
      end
   end

   // Flags stay set until software clears them.
   a_wd_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      flags_q[FLG_WD] && !wr_go |=> flags_q[FLG_WD])
      else $error("watchdog flag cleared on its own");
   a_al_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      flags_q[FLG_AL] && !wr_go |=> flags_q[FLG_AL])
      else $error("alarm flag cleared on its own");
   a_pf_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      flags_q[FLG_PF] && !wr_go |=> flags_q[FLG_PF])
      else $error("power fail flag cleared on its own");
   a_al_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      alarm_match |=> flags_q[FLG_AL])
      else $error("alarm match did not set its flag");
   a_pf_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      powerfail_detect |=> flags_q[FLG_PF])
      else $error("power fail did not set its flag");
   // A masked date matches on every new day, whatever the stored date says.
   a_alarm_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      day_tick && day_q[DAY_MASK_BIT] |=> flags_q[FLG_AL])
      else $error("masked date did not match");
   a_alarm_date: assert property (@(posedge aclk) disable iff (!aresetn)
      day_tick && !day_q[DAY_MASK_BIT] && !flags_q[FLG_AL] &&
      (day_q & DAY_VAL_MASK) != {2'h0, current_day_bcd} |=> !flags_q[FLG_AL])
      else $error("alarm matched a different date");

   // AXI read path.
   always_comb begin
      rdata_d = '0;
      rd_ok   = 1'b1;
      case (s_axi_araddr[IDX_MSB:IDX_LSB])
         ADDR_IRQ_CTRL:  rdata_d[7:0] = ctrl_q & CTRL_WR_MASK;
         ADDR_ALARM_DAY: rdata_d[7:0] = day_q;
         ADDR_FLAGS:     rdata_d[NFLAGS-1:0] = flags_q;
         ADDR_MASK:      rdata_d[NFLAGS-1:0] = mask_q;
         ADDR_DAY_NOW:   rdata_d[5:0] = current_day_bcd;
         default:        rd_ok = 1'b0;
      endcase
   end

   assign flag_read = s_axi_arvalid && s_axi_arready &&
                      s_axi_araddr[IDX_MSB:IDX_LSB] == ADDR_FLAGS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_d;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Read data is captured at the address handshake, so a later change of a
   // source does not reach the master while the answer waits.
   a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read was not answered in time");
   a_ctrl_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[IDX_MSB:IDX_LSB] == ADDR_IRQ_CTRL
      |=> s_axi_rdata[1:0] == 2'h0)
      else $error("reserved control bits read as one");
   a_day_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[IDX_MSB:IDX_LSB] == ADDR_ALARM_DAY
      |=> s_axi_rdata[6] == 1'b0)
      else $error("reserved day alarm bit read as one");

   // Pin activity: pulse mode times out, level mode waits for a flag read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_q <= 1'b0;
         pulse_q  <= '0;
      end else if (|route_d) begin
         active_q <= 1'b1;
         pulse_q  <= PULSE_CNT;
      end else if (ctrl_q[BIT_PL]) begin
         if (pulse_q != '0)
            pulse_q <= pulse_q - 8'h01;
         active_q <= (pulse_q > 8'h01);
      end else if (flag_read) begin
         active_q <= 1'b0;
         pulse_q  <= '0;
      end
   end

   // The timer restarts on every routed event, so a burst of events stretches
   // the pulse; the pin ends a fixed time after the last one.
   a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
      (|route_d) |=> active_q && pulse_q == PULSE_CNT)
      else $error("routed event did not restart the pin timer");
   a_pulse_counts: assert property (@(posedge aclk) disable iff (!aresetn)
      active_q && ctrl_q[BIT_PL] && pulse_q > 8'h01 && !(|route_d)
      |=> active_q && pulse_q == $past(pulse_q) - 8'h01)
      else $error("pulse timer did not count down");
   a_level_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      active_q && !ctrl_q[BIT_PL] && flag_read && !(|route_d) |=> !active_q)
      else $error("flag read did not release the level output");

   // Active high drives both levels; open drain only pulls low when asserted.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_o  <= 1'b0;
         int_oe <= 1'b0;
      end else if (ctrl_q[BIT_HL]) begin
         int_o  <= active_q;
         int_oe <= 1'b1;
      end else begin
         int_o  <= 1'b0;
         int_oe <= active_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(flags_q & mask_q);
   end

   // The irq output trails the status by one edge.
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      (flags_q & mask_q) != '0 |=> irq)
      else $error("unmasked status bit did not raise irq");
   a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      (flags_q & mask_q) == '0 |=> !irq)
      else $error("irq high with no unmasked status bit");
   // Open drain must never drive the line high; it may only pull it low.
   a_od_never_high: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_q[BIT_HL] |=> !int_o)
      else $error("open-drain pin drove a high level");
   a_hl_drives: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_q[BIT_HL] |=> int_oe)
      else $error("active-high pin was released");

   a_wd_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_timeout |=> flags_q[FLG_WD])
      else $error("watchdog event did not set flag");
   a_wd_routes_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_timeout && ctrl_q[BIT_WIE] |=> active_q)
      else $error("enabled watchdog event did not activate pin");
   a_wd_no_route: assert property (@(posedge aclk) disable iff (!aresetn)
      !active_q && watchdog_timeout && !ctrl_q[BIT_WIE] && !route_d[FLG_AL] && !route_d[FLG_PF]
      |=> !active_q)
      else $error("disabled watchdog event activated pin");
   a_al_routes_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      alarm_match && ctrl_q[BIT_AIE] |=> active_q && flags_q[FLG_AL])
      else $error("enabled alarm did not activate pin");
   a_al_no_route: assert property (@(posedge aclk) disable iff (!aresetn)
      !active_q && alarm_match && !ctrl_q[BIT_AIE] && !route_d[FLG_WD] && !route_d[FLG_PF]
      |=> !active_q && flags_q[FLG_AL])
      else $error("disabled alarm activated pin");
   a_pf_routes_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      powerfail_detect && ctrl_q[BIT_POWERFAIL_IRQ_ENABLE] |=> active_q && flags_q[FLG_PF])
      else $error("enabled power fail did not activate pin");
   a_pf_no_route: assert property (@(posedge aclk) disable iff (!aresetn)
      !active_q && powerfail_detect && !ctrl_q[BIT_POWERFAIL_IRQ_ENABLE] && !route_d[FLG_WD] && !route_d[FLG_AL]
      |=> !active_q && flags_q[FLG_PF])
      else $error("disabled power fail activated pin");
   a_pin_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 ($past(ctrl_q[BIT_HL]) ? (int_oe && int_o == $past(active_q))
                                 : (!int_o && int_oe == $past(active_q))))
      else $error("interrupt pin polarity wrong");
   a_ctrl_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_q[1:0] == 2'h0 && day_q[6] == 1'b0)
      else $error("reserved bits stored a one");
   a_level_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      active_q && !ctrl_q[BIT_PL] && !flag_read |=> active_q)
      else $error("level output dropped without flag read");
   a_pulse_ends: assert property (@(posedge aclk) disable iff (!aresetn)
      active_q && ctrl_q[BIT_PL] && pulse_q == 8'h01 && !(|route_d) |=> !active_q)
      else $error("pulse output did not end");
endmodule // rtc_interrupt_routing
`default_nettype wire

// >>> src/rtc_irq_pkg.sv
// Constants for the real-time-clock interrupt routing block.
package rtc_irq_pkg;
   // Register indices; each register's byte address is four times its index.
   localparam logic [16:0] ADDR_ALARM_DAY  = 17'h1fff5;
   localparam logic [16:0] ADDR_IRQ_CTRL   = 17'h1fff6;
   localparam logic [16:0] ADDR_FLAGS      = 17'h1fff8;
   localparam logic [16:0] ADDR_MASK       = 17'h1fffc;
   localparam logic [16:0] ADDR_DAY_NOW    = 17'h1fff0;
   // Interrupt control field positions.
   localparam int BIT_WIE  = 7;
   localparam int BIT_AIE  = 6;
   localparam int BIT_POWERFAIL_IRQ_ENABLE = 5;
   localparam int BIT_ABE  = 4;
   localparam int BIT_HL   = 3;
   localparam int BIT_PL   = 2;
   localparam logic [7:0] CTRL_WR_MASK = 8'hfc;
   // Flag positions, shared by status and mask registers.
   localparam int FLG_WD  = 0;
   localparam int FLG_AL  = 1;
   localparam int FLG_PF  = 2;
   localparam int NFLAGS  = 3;
   // Day alarm fields.
   localparam int DAY_MASK_BIT = 7;
   localparam logic [7:0] DAY_WR_MASK = 8'hbf;
   localparam logic [7:0] DAY_VAL_MASK = 8'h3f;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Pulse length of the interrupt output.
   localparam int PULSE_NS   = 200;
   localparam int CLK_NS     = 10;
   localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] PULSE_CNT = 8'(PULSE_CYC);
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rtc_irq_pkg

// >>> tb/irq_pin_host.sv
// Model of the host's interrupt input: the shared pin with its pull-up.
`timescale 1ns/10ps
`default_nettype none
module irq_pin_host (
   input  wire logic int_o,
   input  wire logic int_oe,
   output logic      pin_level
);
   // The board pull-up holds the line high whenever the block releases it.
   assign pin_level = int_oe ? int_o : 1'b1;
endmodule // irq_pin_host
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the RTC interrupt routing block.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import rtc_irq_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, int_o, int_oe, irq, pin_level;
   logic [1:0]  bresp, rresp;
   logic        wd_ev = 1'b0, pf_ev = 1'b0, day_tick = 1'b0;
   logic [5:0]  day_now = 6'h00, r;
   logic [33:0] q[$];
   int          n_errors = 0, n_compared = 0, cycles = 0, seed = 32'heac5, s, e;

   always #5 aclk = ~aclk;

   rtc_interrupt_routing dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .watchdog_timeout(wd_ev), .powerfail_detect(pf_ev), .day_tick(day_tick),
      .current_day_bcd(day_now), .int_o(int_o), .int_oe(int_oe), .irq(irq));
   irq_pin_host host (.int_o(int_o), .int_oe(int_oe), .pin_level(pin_level));

   task automatic wrap_up();
      if (n_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [33:0] seen, input logic [33:0] want);
      n_compared++;
      if (seen !== want) begin
         n_errors++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   // Ready is sampled mid-cycle so the release lands just after the taking edge.
   task automatic wr(input logic [16:0] a, input logic [7:0] d, input logic [1:0] er);
      logic pa, pw, ra, rw, b;
      @(posedge aclk);
      awaddr <= {13'h0, a, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ra = awready;
         rw = wready;
         @(posedge aclk);
         if (pa && ra) begin awvalid <= 1'b0; pa = 1'b0; end
         if (pw && rw) begin wvalid <= 1'b0; pw = 1'b0; end
      end
      do begin @(negedge aclk); b = bvalid; @(posedge aclk); end while (!b);
      chk(34'(bresp), 34'(er));
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [16:0] a, input logic [7:0] x, input logic [1:0] rs);
      logic b;
      q.push_back({rs, 24'h0, x});
      @(posedge aclk);
      araddr <= {13'h0, a, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(negedge aclk); b = arready; @(posedge aclk); end while (!b);
      arvalid <= 1'b0;
      do begin @(negedge aclk); b = rvalid; @(posedge aclk); end while (!b);
      rready <= 1'b0;
   endtask

   task automatic ev(input int k);
      @(posedge aclk);
      wd_ev <= (k == 0);
      day_tick <= (k == 1);
      pf_ev <= (k == 2);
      @(posedge aclk);
      {wd_ev, day_tick, pf_ev} <= 3'h0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   always @(posedge aclk) if (rvalid && rready) chk({rresp, rdata}, q.pop_front());

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 6000) begin
         n_errors++;
         wrap_up();
      end
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
      rd(ADDR_ALARM_DAY, 8'h00, RESP_OKAY);
      rd(17'h1fff4, 8'h00, RESP_SLVERR);
      wr(17'h1fff4, 8'h5a, RESP_SLVERR);
      wr(ADDR_IRQ_CTRL, CTRL_WR_MASK, RESP_OKAY);
      rd(ADDR_IRQ_CTRL, CTRL_WR_MASK, RESP_OKAY);
      wr(ADDR_ALARM_DAY, 8'hff, RESP_OKAY);
      rd(ADDR_ALARM_DAY, DAY_WR_MASK, RESP_OKAY);
      wr(ADDR_ALARM_DAY, 8'h80, RESP_OKAY);
      wr(ADDR_MASK, 8'h07, RESP_OKAY);
      rd(ADDR_MASK, 8'h07, RESP_OKAY);
      day_now <= 6'($random(seed));
      for (s = 0; s < 3; s++) for (e = 0; e < 2; e++) begin
         wr(ADDR_IRQ_CTRL, (e != 0 ? (8'h80 >> s) : 8'h00) | 8'h08, RESP_OKAY);
         ev(s);
         settle(3);
         chk(34'(pin_level), 34'(e));
         chk(34'(irq), 34'h1);
         rd(ADDR_FLAGS, 8'h01 << s, RESP_OKAY);
         settle(2);
         chk(34'(pin_level), 34'h0);
         wr(ADDR_FLAGS, 8'h01 << s, RESP_OKAY);
         settle(2);
         chk(34'(irq), 34'h0);
      end
      rd(ADDR_DAY_NOW, {2'h0, day_now}, RESP_OKAY);
      // Open-drain with the status masked: the pin still fires, irq stays low.
      wr(ADDR_MASK, 8'h00, RESP_OKAY);
      wr(ADDR_IRQ_CTRL, 8'h80, RESP_OKAY);
      settle(1);
      chk(34'({int_oe, pin_level}), 34'h1);
      ev(0);
      settle(3);
      chk(34'({int_o, int_oe, pin_level, irq}), 34'h4);
      rd(ADDR_FLAGS, 8'h01, RESP_OKAY);
      settle(2);
      chk(34'(pin_level), 34'h1);
      wr(ADDR_FLAGS, 8'h01, RESP_OKAY);
      wr(ADDR_IRQ_CTRL, 8'h8c, RESP_OKAY);
      ev(0);
      settle(PULSE_CYC);
      chk(34'(pin_level), 34'h1);
      settle(1);
      chk(34'(pin_level), 34'h0);
      wr(ADDR_FLAGS, 8'h01, RESP_OKAY);
      r = 6'($random(seed));
      wr(ADDR_IRQ_CTRL, 8'h48, RESP_OKAY);
      wr(ADDR_ALARM_DAY, {2'h0, r}, RESP_OKAY);
      day_now <= r ^ 6'h01;
      ev(1);
      settle(3);
      chk(34'(pin_level), 34'h0);
      day_now <= r;
      ev(1);
      settle(3);
      chk(34'(pin_level), 34'h1);
      rd(ADDR_FLAGS, 8'h02, RESP_OKAY);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
